/* File: core/acf_pkg.sv */
// Shared constants and types for the asynchronous character framer.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package acf_pkg;

    // =====================================================
    // Clock and framing constants
    // =====================================================
    localparam int unsigned ACF_CLOCK_HZ = 200_000_000;
    localparam int unsigned ACF_BAUD_DEFAULT = 115_200;
    localparam int unsigned ACF_DIV_W = 16;
    localparam int unsigned ACF_OVERSAMPLE = 16;
    localparam logic [4:0] ACF_OS_LAST = 5'h0f;
    localparam logic [4:0] ACF_OS_MID = 5'h07;
    localparam logic [4:0] ACF_OS_HALF_LAST = 5'h07;
    localparam logic [4:0] ACF_OS_1P5_LAST = 5'h17;
    localparam logic [3:0] ACF_DATA_BASE = 4'h5;
    localparam logic ACF_MARK = 1'b1;
    localparam logic ACF_SPACE = 1'b0;

    // =====================================================
    // Configuration encodings
    // =====================================================
    typedef enum logic [1:0] {
        ACF_PAR_NONE = 2'h0,
        ACF_PAR_EVEN = 2'h1,
        ACF_PAR_ODD = 2'h2
    } acf_parity_t;

    typedef enum logic [1:0] {
        ACF_STOP_1 = 2'h0,
        ACF_STOP_1P5 = 2'h1,
        ACF_STOP_2 = 2'h2
    } acf_stop_t;

    // =====================================================
    // Frame sequencer states, shared by both directions
    // =====================================================
    typedef enum logic [4:0] {
        ACF_IDLE = 5'b0_0001,
        ACF_START = 5'b0_0010,
        ACF_DATA = 5'b0_0100,
        ACF_PARITY = 5'b0_1000,
        ACF_STOP = 5'b1_0000
    } acf_state_t;

endpackage

/* File: core/acf_rx.sv */
// Receiver half of the asynchronous character framer.
// Assumes serial_in is already synchronised and tick is a 16x bit-rate enable.
module acf_rx (
    input wire logic clock,
    input wire logic srst,
    input wire logic tick,
    input wire logic serial_in,
    input wire logic [1:0] data_bits,
    input wire acf_pkg::acf_parity_t parity_mode,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_parity_error,
    output logic rx_framing_error
);

    // =====================================================
    // State
    // =====================================================
    acf_pkg::acf_state_t state, next_state;
    logic [4:0] os, next_os;
    logic [2:0] bit_idx, next_bit_idx;
    logic [7:0] shift, next_shift;
    logic par_acc, next_par_acc;
    logic par_err, next_par_err;
    logic [7:0] next_rx_data;
    logic next_rx_valid, next_rx_parity_error, next_rx_framing_error;
    logic [3:0] nbits;
    logic mid;

    assign nbits = acf_pkg::ACF_DATA_BASE + {2'b00, data_bits};
    assign mid = tick && (os == acf_pkg::ACF_OS_MID);

    // =====================================================
    // Next-state logic
    // =====================================================
    always_comb begin
        next_state = state;
        next_os = os;
        next_bit_idx = bit_idx;
        next_shift = shift;
        next_par_acc = par_acc;
        next_par_err = par_err;
        next_rx_data = rx_data;
        next_rx_valid = 1'b0;
        next_rx_parity_error = 1'b0;
        next_rx_framing_error = 1'b0;
        if (tick && state != acf_pkg::ACF_IDLE) begin
            next_os = (os == acf_pkg::ACF_OS_LAST) ? 5'h00 : os + 5'h01;
        end
        case (state)
            acf_pkg::ACF_IDLE: begin
                if (tick && serial_in == acf_pkg::ACF_SPACE) begin
                    next_state = acf_pkg::ACF_START;
                    next_os = 5'h01;
                end
            end
            acf_pkg::ACF_START: begin
                // Glitch rejection: a start bit must still be low at its centre.
                if (mid) begin
                    if (serial_in != acf_pkg::ACF_SPACE) begin
                        next_state = acf_pkg::ACF_IDLE;
                        next_os = 5'h00;
                    end else begin
                        next_state = acf_pkg::ACF_DATA;
                        next_os = acf_pkg::ACF_OS_MID + 5'h01;
                        next_bit_idx = 3'h0;
                        next_shift = 8'h00;
                        next_par_acc = 1'b0;
                        next_par_err = 1'b0;
                    end
                end
            end
            acf_pkg::ACF_DATA: begin
                if (mid) begin
                    next_shift = {serial_in, shift[7:1]}; // [RL2] [RL9]
                    next_par_acc = par_acc ^ serial_in;
                    if ({1'b0, bit_idx} == nbits - 4'h1) begin // [RL4]
                        next_state = (parity_mode == acf_pkg::ACF_PAR_NONE) ?
                            acf_pkg::ACF_STOP : acf_pkg::ACF_PARITY; // [RL7]
                    end else begin
                        next_bit_idx = bit_idx + 3'h1;
                    end
                end
            end
            acf_pkg::ACF_PARITY: begin
                if (mid) begin
                    next_par_err = (par_acc ^ serial_in) !=
                        (parity_mode == acf_pkg::ACF_PAR_ODD); // [RL10]
                    next_state = acf_pkg::ACF_STOP;
                end
            end
            acf_pkg::ACF_STOP: begin
                // Only the first stop bit is checked so back-to-back frames resync early.
                if (mid) begin
                    next_state = acf_pkg::ACF_IDLE;
                    next_os = 5'h00;
                    next_rx_data = shift >> (4'h8 - nbits); // [RL2] [RL4]
                    next_rx_valid = 1'b1;
                    next_rx_parity_error = par_err; // [RL10]
                    next_rx_framing_error = serial_in != acf_pkg::ACF_MARK; // [RL10]
                end
            end
            default: begin
                next_state = acf_pkg::ACF_IDLE;
            end
        endcase
    end

    // =====================================================
    // Registers
    // =====================================================
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= acf_pkg::ACF_IDLE;
            os <= 5'h00;
            bit_idx <= 3'h0;
            shift <= 8'h00;
            par_acc <= 1'b0;
            par_err <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_parity_error <= 1'b0;
            rx_framing_error <= 1'b0;
        end else begin
            state <= next_state;
            os <= next_os;
            bit_idx <= next_bit_idx;
            shift <= next_shift;
            par_acc <= next_par_acc;
            par_err <= next_par_err;
            rx_data <= next_rx_data;
            rx_valid <= next_rx_valid;
            rx_parity_error <= next_rx_parity_error;
            rx_framing_error <= next_rx_framing_error;
        end
    end

endmodule

/* File: core/acf_framer.sv */
// Top of the asynchronous character framer: baud divider, transmitter, receiver.
// Assumes one 200 MHz clock, synchronous reset, serial_in arriving from a pin.
// Assumes the framing inputs are held steady while a character is in flight.
// Assumes the far end uses the same divisor, data length, parity and stop settings.
//
// Functional notes
// RL1: Transmit character bits serially on one line.
// RL2: Receiver reassembles serial bits into characters.
// RL3: Each character starts with one start bit.
// RL4: Five to eight data bits, both directions.
// RL5: Stop period of 1, 1.5 or 2 bits.
// RL6: Parity bit follows data, precedes stop.
// RL7: Parity selects even, odd or none.
// RL8: Both link ends share identical framing settings.
// RL9: LSB first; idle mark; start is space.
// RL10: Flag parity errors and low stop bits.
module acf_framer (
    input wire logic clock,
    input wire logic srst,
    input wire logic [15:0] baud_divisor,
    input wire logic [1:0] data_bits,
    input wire acf_pkg::acf_parity_t parity_mode,
    input wire acf_pkg::acf_stop_t stop_mode,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic serial_out,
    input wire logic serial_in,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_parity_error,
    output logic rx_framing_error
);

    // =====================================================
    // Oversampling tick divider
    // =====================================================
    // One divisor serves both directions, so the transmitter and receiver run at the same rate.
    // The divider runs free, so the first bit of a frame may be up to one tick short.
    logic [15:0] div_cnt, next_div_cnt;
    logic tick;

    assign tick = (div_cnt == 16'h0000); // [RL8]

    always_comb begin
        next_div_cnt = tick ? baud_divisor : div_cnt - 16'h0001;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // =====================================================
    // Input synchroniser
    // =====================================================
    // Only the second flop is read, so a metastable first stage never reaches the receiver.
    logic rx_meta, rx_sync;
    logic next_rx_meta, next_rx_sync;

    always_comb begin
        next_rx_meta = serial_in;
        next_rx_sync = rx_meta;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rx_meta <= acf_pkg::ACF_MARK;
            rx_sync <= acf_pkg::ACF_MARK;
        end else begin
            rx_meta <= next_rx_meta;
            rx_sync <= next_rx_sync;
        end
    end

    // =====================================================
    // Transmitter
    // =====================================================
    acf_pkg::acf_state_t tx_state, next_tx_state;
    logic [4:0] tx_os, next_tx_os;
    logic [2:0] tx_idx, next_tx_idx;
    logic [7:0] tx_shift, next_tx_shift;
    logic tx_par, next_tx_par;
    logic stop_second, next_stop_second;
    logic next_serial_out;
    logic [3:0] tx_nbits;
    logic bit_end;

    assign tx_nbits = acf_pkg::ACF_DATA_BASE + {2'b00, data_bits};
    assign bit_end = tick && (tx_os == acf_pkg::ACF_OS_LAST);
    // Requests while busy are ignored without notice; the source must wait for ready.
    assign tx_ready = (tx_state == acf_pkg::ACF_IDLE);

    // =====================================================
    // Transmit bit timer
    // =====================================================
    // Held at zero while idle, so every start bit counts its ticks from a clean origin.
    always_comb begin
        if (tx_state == acf_pkg::ACF_IDLE || bit_end) begin
            next_tx_os = 5'h00;
        end else if (tick) begin
            next_tx_os = tx_os + 5'h01;
        end else begin
            next_tx_os = tx_os;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            tx_os <= 5'h00;
        end else begin
            tx_os <= next_tx_os;
        end
    end

    // =====================================================
    // Transmit sequencer
    // =====================================================
    always_comb begin
        next_tx_state = tx_state;
        next_tx_idx = tx_idx;
        next_tx_shift = tx_shift;
        next_tx_par = tx_par;
        next_stop_second = stop_second;
        next_serial_out = serial_out;
        case (tx_state)
            acf_pkg::ACF_IDLE: begin
                next_serial_out = acf_pkg::ACF_MARK; // [RL9]
                if (tx_valid) begin
                    next_tx_state = acf_pkg::ACF_START;
                    next_tx_shift = tx_data;
                    // The unused parity code falls back to even, matching the receiver.
                    next_tx_par = (parity_mode == acf_pkg::ACF_PAR_ODD); // [RL7]
                    next_tx_idx = 3'h0;
                    next_stop_second = 1'b0;
                    next_serial_out = acf_pkg::ACF_SPACE; // [RL3] [RL9]
                end
            end
            acf_pkg::ACF_START: begin
                if (bit_end) begin
                    next_tx_state = acf_pkg::ACF_DATA;
                    next_serial_out = tx_shift[0]; // [RL1] [RL9]
                end
            end
            acf_pkg::ACF_DATA: begin
                if (bit_end) begin
                    next_tx_par = tx_par ^ tx_shift[0];
                    next_tx_shift = {1'b0, tx_shift[7:1]};
                    if ({1'b0, tx_idx} == tx_nbits - 4'h1) begin // [RL4]
                        if (parity_mode == acf_pkg::ACF_PAR_NONE) begin // [RL7]
                            next_tx_state = acf_pkg::ACF_STOP;
                            next_serial_out = acf_pkg::ACF_MARK;
                        end else begin
                            next_tx_state = acf_pkg::ACF_PARITY;
                            next_serial_out = tx_par ^ tx_shift[0]; // [RL6]
                        end
                    end else begin
                        next_tx_idx = tx_idx + 3'h1;
                        next_serial_out = tx_shift[1]; // [RL1]
                    end
                end
            end
            acf_pkg::ACF_PARITY: begin
                if (bit_end) begin
                    next_tx_state = acf_pkg::ACF_STOP; // [RL6]
                    next_serial_out = acf_pkg::ACF_MARK;
                end
            end
            acf_pkg::ACF_STOP: begin
                // The half bit of a 1.5 stop is timed by the oversample counter.
                next_serial_out = acf_pkg::ACF_MARK;
                if (tick && !stop_second && tx_os == acf_pkg::ACF_OS_LAST) begin
                    if (stop_mode == acf_pkg::ACF_STOP_1) begin // [RL5]
                        next_tx_state = acf_pkg::ACF_IDLE;
                    end else begin
                        next_stop_second = 1'b1;
                    end
                end else if (tick && stop_second) begin
                    if ((stop_mode == acf_pkg::ACF_STOP_1P5 && tx_os == acf_pkg::ACF_OS_HALF_LAST) ||
                        (stop_mode != acf_pkg::ACF_STOP_1P5 && tx_os == acf_pkg::ACF_OS_LAST)) begin // [RL5]
                        next_tx_state = acf_pkg::ACF_IDLE;
                    end
                end
            end
            default: begin
                next_tx_state = acf_pkg::ACF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            tx_state <= acf_pkg::ACF_IDLE;
            tx_idx <= 3'h0;
            tx_shift <= 8'h00;
            tx_par <= 1'b0;
            stop_second <= 1'b0;
            serial_out <= acf_pkg::ACF_MARK;
        end else begin
            tx_state <= next_tx_state;
            tx_idx <= next_tx_idx;
            tx_shift <= next_tx_shift;
            tx_par <= next_tx_par;
            stop_second <= next_stop_second;
            serial_out <= next_serial_out;
        end
    end

    // =====================================================
    // Receiver
    // =====================================================
    // The receiver shares the tick, so its bit rate always matches the transmitter.
    acf_rx u_rx (
        .clock(clock),
        .srst(srst),
        .tick(tick),
        .serial_in(rx_sync),
        .data_bits(data_bits),
        .parity_mode(parity_mode),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .rx_parity_error(rx_parity_error),
        .rx_framing_error(rx_framing_error)
    );

endmodule

/* File: test/acf_framer_chk.sv */
// Checker for the framer top: transmit timing and receive flag relations.
// Assumes it is bound onto acf_framer and the framing settings stay put during a frame.
module acf_framer_chk (
    input wire logic clock,
    input wire logic srst,
    input wire logic [15:0] baud_divisor,
    input wire logic [1:0] data_bits,
    input wire acf_pkg::acf_parity_t parity_mode,
    input wire acf_pkg::acf_stop_t stop_mode,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic serial_out,
    input wire logic serial_in,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_parity_error,
    input wire logic rx_framing_error
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // =====================================================
    // Frame length window
    // =====================================================
    // The first bit may be up to a tick short, so the length is checked in a window.
    logic [15:0] busy;
    logic [15:0] next_busy;
    int unit;
    int ticks;
    assign unit = int'(baud_divisor) + 1;
    assign ticks = 16 * (6 + int'(data_bits) + int'(parity_mode != acf_pkg::ACF_PAR_NONE))
        + (stop_mode == acf_pkg::ACF_STOP_1 ? 16 : stop_mode == acf_pkg::ACF_STOP_1P5 ? 24 : 32);
    always_comb begin
        next_busy = (srst || tx_ready) ? 16'h0000 : busy + 16'h0001;
    end
    always_ff @(posedge clock) begin
        busy <= next_busy;
    end
    chk_take_start: assert property (tx_valid && tx_ready |=> !serial_out && !tx_ready)
        else $error("no start bit after accepted request");
    chk_idle_mark: assert property (tx_ready |-> serial_out)
        else $error("line not at mark while idle");
    chk_start_held: assert property ($fell(serial_out) |-> !serial_out [*8])
        else $error("start bit too short");
    chk_bit_hold: assert property (!tx_ready && $changed(serial_out) |=> $stable(serial_out) [*8])
        else $error("bit changed too soon");
    chk_frame_len: assert property ($rose(tx_ready) |-> int'(busy) >= (ticks - 1) * unit - 2
        && int'(busy) <= (ticks + 1) * unit + 2)
        else $error("frame length wrong");
    chk_valid_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("receive strobe longer than one cycle");
    chk_flag_valid: assert property (rx_parity_error || rx_framing_error |-> rx_valid)
        else $error("error flag without character");
    chk_char_width: assert property (rx_valid |-> (rx_data >> (5 + data_bits)) == 8'h00)
        else $error("received bits beyond length");
    cov_parity_err: cover property (rx_valid && rx_parity_error);
    cov_frame_err: cover property (rx_valid && rx_framing_error);
    cov_half_stop: cover property (tx_valid && tx_ready && stop_mode == acf_pkg::ACF_STOP_1P5);
endmodule
bind acf_framer acf_framer_chk u_chk (.clock, .srst, .baud_divisor, .data_bits, .parity_mode, .stop_mode,
    .tx_data, .tx_valid, .tx_ready, .serial_out, .serial_in, .rx_data, .rx_valid, .rx_parity_error,
    .rx_framing_error);

/* File: test/acf_peer.sv */
// Remote serial end: sends characters to the framer and decodes what it sends.
// Assumes the same settings as the framer and a line that idles at mark.
module acf_peer (
    input wire logic clock,
    input wire logic line_in,
    input wire logic [1:0] data_bits,
    input wire acf_pkg::acf_parity_t parity_mode,
    input wire acf_pkg::acf_stop_t stop_mode,
    input wire logic [15:0] baud_divisor,
    output logic line_out,
    output logic got_valid,
    output logic [9:0] got_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================
    // Sender and decoder
    // =====================================================
    int bit_clk;
    logic [7:0] d;
    logic p;
    logic ok;
    logic sok;
    assign bit_clk = 16 * (int'(baud_divisor) + 1);
    initial line_out = 1'b1;
    // A bad stop bit is cut short after mid-bit so that it cannot pass for a new start.
    task automatic send(input logic [7:0] v, input logic bad_par, input logic bad_stop);
        logic q;
        int h;
        q = (parity_mode == acf_pkg::ACF_PAR_ODD);
        h = stop_mode == acf_pkg::ACF_STOP_1 ? 2 : stop_mode == acf_pkg::ACF_STOP_1P5 ? 3 : 4;
        @(negedge clock) line_out = 1'b0;
        repeat (bit_clk) @(negedge clock);
        for (int i = 0; i < 5 + int'(data_bits); i++) begin
            line_out = v[i];
            q ^= v[i];
            repeat (bit_clk) @(negedge clock);
        end
        if (parity_mode != acf_pkg::ACF_PAR_NONE) begin
            line_out = q ^ bad_par;
            repeat (bit_clk) @(negedge clock);
        end
        line_out = !bad_stop;
        repeat (bit_clk / 2 + 4) @(negedge clock);
        line_out = 1'b1;
        repeat (h * bit_clk / 2 - bit_clk / 2 - 4) @(negedge clock);
    endtask
    initial begin
        got_valid = 1'b0;
        got_word = 10'h000;
        forever begin
            @(negedge line_in);
            repeat (bit_clk / 2) @(negedge clock);
            ok = !line_in;
            d = 8'h00;
            p = (parity_mode == acf_pkg::ACF_PAR_ODD);
            for (int i = 0; i < 5 + int'(data_bits); i++) begin
                repeat (bit_clk) @(negedge clock);
                d[i] = line_in;
                p ^= line_in;
            end
            if (parity_mode != acf_pkg::ACF_PAR_NONE) begin
                repeat (bit_clk) @(negedge clock);
                ok &= (line_in == p);
            end
            repeat (bit_clk) @(negedge clock);
            sok = line_in;
            if (stop_mode == acf_pkg::ACF_STOP_2) begin
                repeat (bit_clk) @(negedge clock);
                sok &= line_in;
            end
            got_word = {sok, ok, d};
            got_valid = 1'b1;
            @(negedge clock);
            got_valid = 1'b0;
        end
    end
endmodule

/* File: test/tb.sv */
// Self-checking bench: all framing settings, both directions, against the peer model.
// Assumes the design files and the peer model are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [15:0] baud_divisor = 16'h0001;
    logic [1:0] data_bits = 2'h3;
    acf_pkg::acf_parity_t parity_mode = acf_pkg::ACF_PAR_NONE;
    acf_pkg::acf_stop_t stop_mode = acf_pkg::ACF_STOP_1;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic tx_ready, serial_out, serial_in, rx_valid, rx_parity_error, rx_framing_error, got_valid;
    logic [7:0] rx_data;
    logic [9:0] got_word;
    logic [9:0] exp_tx[$];
    logic [9:0] exp_rx[$];
    logic [31:0] seed = 32'h0000_1d02;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #2.5 clock = ~clock;
    acf_framer u_dut (.clock, .srst, .baud_divisor, .data_bits, .parity_mode, .stop_mode, .tx_data,
        .tx_valid, .tx_ready, .serial_out, .serial_in, .rx_data, .rx_valid, .rx_parity_error, .rx_framing_error);
    acf_peer u_peer (.clock, .line_in(serial_out), .data_bits, .parity_mode, .stop_mode, .baud_divisor,
        .line_out(serial_in), .got_valid, .got_word);
    // =====================================================
    // Helpers
    // =====================================================
    function automatic logic [7:0] mask(input logic [7:0] v);
        return v & (8'hff >> (2'h3 - data_bits));
    endfunction
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic check_tx(input logic [9:0] got);
        logic [9:0] exp;
        exp = 10'h000;
        samples_checked++;
        if (exp_tx.size() == 0) begin
            mismatches++;
            $display("MISMATCH tx_frame expected none seen %h", got);
        end else begin
            exp = exp_tx.pop_front();
            if (got !== exp) begin
                mismatches++;
                $display("MISMATCH tx_frame expected %h seen %h", exp, got);
            end
        end
    endtask
    task automatic check_rx(input logic [9:0] got);
        logic [9:0] exp;
        exp = 10'h000;
        samples_checked++;
        if (exp_rx.size() == 0) begin
            mismatches++;
            $display("MISMATCH rx_char expected none seen %h", got);
        end else begin
            exp = exp_rx.pop_front();
            if (got !== exp) begin
                mismatches++;
                $display("MISMATCH rx_char expected %h seen %h", exp, got);
            end
        end
    endtask
    task automatic report_and_stop();
        if (exp_tx.size() + exp_rx.size() != 0) begin
            mismatches++;
        end
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic drive_tx(input logic [7:0] v);
        int n;
        exp_tx.push_back({2'b11, mask(v)});
        @(negedge clock);
        tx_data = v;
        tx_valid = 1'b1;
        n = 0;
        while (tx_ready !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        tx_valid = 1'b0;
    endtask
    // =====================================================
    // Stimulus and watchers
    // =====================================================
    initial begin
        repeat (6) @(negedge clock);
        srst = 1'b0;
        for (int c = 0; c < 36; c++) begin
            @(negedge clock);
            baud_divisor = 16'((c + c / 9) % 3);
            data_bits = 2'(c / 9);
            parity_mode = acf_pkg::acf_parity_t'(2'((c / 3) % 3));
            stop_mode = acf_pkg::acf_stop_t'(2'(c % 3));
            seed = xorshift(seed);
            exp_rx.push_back({seed[9] & seed[10], seed[8] & (parity_mode != acf_pkg::ACF_PAR_NONE), mask(seed[7:0])});
            fork
                begin
                    drive_tx(seed[7:0]);
                    drive_tx(seed[23:16]);
                end
                u_peer.send(seed[7:0], seed[8], seed[9] & seed[10]);
            join
            while (tx_ready !== 1'b1) @(negedge clock);
            repeat (40) @(negedge clock);
        end
        report_and_stop();
    end
    always @(posedge got_valid) check_tx(got_word);
    always @(negedge clock) begin
        if (rx_valid === 1'b1) begin
            check_rx({rx_framing_error, rx_parity_error, rx_data});
        end
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            report_and_stop();
        end
    end
endmodule
